// ==== verilog/dpwm_map.svh ====
/*
  Register indices, field positions and reset values of the dual PWM.
  Assumes byte address = index * 4 on a 32-bit AXI4-Lite bus.
*/
`ifndef DPWM_MAP_SVH
`define DPWM_MAP_SVH

// ****************************************************************
// Register indices (byte address = index * 4)
// ****************************************************************
`define DPWM_IDX_C0_SCALE 16'ha088
`define DPWM_IDX_C0_DUTY  16'ha089
`define DPWM_IDX_C1_SCALE 16'ha08a
`define DPWM_IDX_C1_DUTY  16'ha08b
`define DPWM_IDX_FLAG_EN  16'ha08c
`define DPWM_IDX_PIN_SEL  16'ha08d

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define DPWM_REG_RST      8'h00
`define DPWM_FLAG_C0_BIT  7
`define DPWM_FLAG_C1_BIT  6
`define DPWM_EN_C0_BIT    3
`define DPWM_EN_C1_BIT    2
`define DPWM_SEL_C0_LSB   0
`define DPWM_SEL_C1_LSB   4
`define DPWM_CODE_LSB     5
`define DPWM_CODE_OFF_LO  3'h0
`define DPWM_CODE_OFF_HI  3'h7
`define DPWM_CYC_LAST     8'hff
`define DPWM_RESP_OKAY    2'h0
`define DPWM_RESP_SLVERR  2'h2

`endif

// ==== verilog/dpwm_pkg.sv ====
/*
  Types of the dual PWM block: state records of top and channel.
  Assumes dpwm_map.svh supplies all numeric constants.
*/
package dpwm_pkg;

  // ****************************************************************
  // Channel state
  // ****************************************************************
  typedef struct packed {
    logic [6:0] presc;
    logic [4:0] div;
    logic [7:0] cnt;
    logic [7:0] duty;
    logic       level;
    logic       cend;
  } dpwm_chan_st_t;

  // ****************************************************************
  // Top state: registers, bus slave, pins
  // ****************************************************************
  typedef struct packed {
    logic [1:0][7:0] scale;
    logic [1:0][7:0] duty;
    logic [1:0]      flag;
    logic [1:0]      en;
    logic [1:0]      sel0;
    logic [1:0]      sel1;
    logic [2:0]      pin0;
    logic [3:0]      pin1;
    logic            irq;
    logic            awready;
    logic            aw_held;
    logic [15:0]     aw_idx;
    logic            wready;
    logic            w_held;
    logic [7:0]      wdata;
    logic            wstrb0;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            arready;
    logic            rvalid;
    logic [7:0]      rdata;
    logic [1:0]      rresp;
  } dpwm_top_st_t;

endpackage

// ==== verilog/dpwm_chan_if.sv ====
/*
  Link between the register side and one PWM channel.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/100ps

interface dpwm_chan_if;
  logic [7:0] scale;
  logic [7:0] duty;
  logic       level;
  logic       cycle_end;

  modport ctrl (output scale, output duty, input level, input cycle_end);
  modport chan (input scale, input duty, output level, output cycle_end);
endinterface

// ==== verilog/dpwm_chan.sv ====
/*
  One PWM channel: prescaler, divider, 8-bit counter, duty compare.
  Assumes scale and shadow duty come from registers on the same clock.
*/
`timescale 1ns/100ps
`include "dpwm_map.svh"

module dpwm_chan (
  input  wire logic  aclk,     // System clock
  input  wire logic  aresetn,  // Synchronous reset, low
  dpwm_chan_if.chan  bus       // Settings in, level out
);

  dpwm_pkg::dpwm_chan_st_t st_r;
  dpwm_pkg::dpwm_chan_st_t st_nxt;
  logic [2:0]  code;
  logic [4:0]  div;
  logic        active;
  logic [7:0]  pmax;
  logic        presc_last;
  logic        tick;

  // ****************************************************************
  // Counting clock
  // ****************************************************************
  assign code = bus.scale[7:`DPWM_CODE_LSB];
  assign div = bus.scale[4:0];
  assign active = (code != `DPWM_CODE_OFF_LO) && (code != `DPWM_CODE_OFF_HI);
  assign pmax = 8'((8'h02 << code) - 8'h01);
  assign presc_last = ({1'b0, st_r.presc} == pmax);
  assign tick = active && presc_last && (st_r.div >= div);

  always_comb begin
    st_nxt = st_r;
    st_nxt.cend = 1'b0;
    if (!active) begin
      st_nxt.presc = 7'h00;
      st_nxt.div = 5'h00;
      st_nxt.cnt = 8'h00;
      st_nxt.duty = bus.duty;
    end else begin
      st_nxt.presc = presc_last ? 7'h00 : 7'(st_r.presc + 7'h01);
      if (presc_last) begin
        st_nxt.div = tick ? 5'h00 : 5'(st_r.div + 5'h01);
      end
      if (tick) begin
        st_nxt.cnt = 8'(st_r.cnt + 8'h01);
        if (st_r.cnt == `DPWM_CYC_LAST) begin
          st_nxt.duty = bus.duty;
          st_nxt.cend = 1'b1;
        end
      end
    end
    if (code == `DPWM_CODE_OFF_HI) begin
      st_nxt.level = 1'b1;
    end else if (code == `DPWM_CODE_OFF_LO) begin
      st_nxt.level = 1'b0;
    end else begin
      st_nxt.level = (st_nxt.cnt < st_nxt.duty);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bus.level = st_r.level;
  assign bus.cycle_end = st_r.cend;

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic [12:0] gap_r;
  logic        seen_r;
  logic [7:0]  scale_q_r;
  logic [12:0] per_m1;

  assign per_m1 = 13'((13'h0002 << code) * ({8'h00, div} + 13'h0001)
                  - 13'h0001);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap_r <= 13'h0000;
      seen_r <= 1'b0;
      scale_q_r <= 8'h00;
    end else begin
      gap_r <= tick ? 13'h0000 : 13'(gap_r + 13'h0001);
      scale_q_r <= bus.scale;
      if (!active || bus.scale != scale_q_r) begin
        seen_r <= 1'b0;
      end else if (tick) begin
        seen_r <= 1'b1;
      end
    end
  end

  property p_tick_gap;
    @(posedge aclk) disable iff (!aresetn)
    tick && seen_r && bus.scale == scale_q_r |-> gap_r == per_m1;
  endproperty
  a_tick_gap: assert property (p_tick_gap)
    else $error("Counting clock period wrong");

  property p_wrap;
    @(posedge aclk) disable iff (!aresetn)
    tick && st_r.cnt == `DPWM_CYC_LAST |=> st_r.cnt == 8'h00 && bus.cycle_end;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("Counter did not wrap after 256 counts");

  property p_hold;
    @(posedge aclk) disable iff (!aresetn)
    !active |=> bus.level == ($past(code) == `DPWM_CODE_OFF_HI);
  endproperty
  a_hold: assert property (p_hold)
    else $error("Disabled channel level wrong");

  property p_duty_hold;
    @(posedge aclk) disable iff (!aresetn)
    active && !(tick && st_r.cnt == `DPWM_CYC_LAST) |=> $stable(st_r.duty);
  endproperty
  a_duty_hold: assert property (p_duty_hold)
    else $error("Active duty changed mid-cycle");

  property p_max_duty;
    @(posedge aclk) disable iff (!aresetn)
    active ##0 st_r.cnt == `DPWM_CYC_LAST [*2] |-> !bus.level;
  endproperty
  a_max_duty: assert property (p_max_duty)
    else $error("Output active at last count");

  c_wrap: cover property (@(posedge aclk) disable iff (!aresetn)
    bus.cycle_end);

endmodule

// ==== verilog/dpwm_top.sv ====
/*
  Dual 8-bit PWM with AXI4-Lite register slave, flags and pin routing.
  Assumes one clock, synchronous active-low reset, a single bus master.
*/
`timescale 1ns/100ps
`include "dpwm_map.svh"

// Contract
// - Each channel counts 8 bits; one period is 256 counting clocks.
// - Counting clock is system clock over prescale code factor, then divider.
// - Divider field 0..31 divides by one to thirty-two.
// - Code 000 disables and holds low; code 111 disables and holds high.
// - Written duty waits in a shadow, loaded at cycle end, or every clock while the channel is disabled.
// - Maximum duty is 255/256; output never stays active all period.
// - Each channel has its own scale and duty registers.
// - Flag set at cycle end only while enabled; flag raises interrupt.
// - Each channel output routes to one of its own candidate pins; a select with no matching pin drives none.
module dpwm_top #(
  parameter int ADDR_W = 18,  // Byte address width
  parameter int PINS0  = 3,   // Candidate pins of channel 0
  parameter int PINS1  = 4    // Candidate pins of channel 1
) (
  input  wire logic              aclk,           // System clock
  input  wire logic              aresetn,        // Synchronous reset, low
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,   // Write address
  input  wire logic              s_axi_awvalid,  // Write address valid
  output logic                   s_axi_awready,  // Write address ready
  input  wire logic [31:0]       s_axi_wdata,    // Write data
  input  wire logic [3:0]        s_axi_wstrb,    // Write byte strobes
  input  wire logic              s_axi_wvalid,   // Write data valid
  output logic                   s_axi_wready,   // Write data ready
  output logic [1:0]             s_axi_bresp,    // Write response
  output logic                   s_axi_bvalid,   // Write response valid
  input  wire logic              s_axi_bready,   // Write response ready
  input  wire logic [ADDR_W-1:0] s_axi_araddr,   // Read address
  input  wire logic              s_axi_arvalid,  // Read address valid
  output logic                   s_axi_arready,  // Read address ready
  output logic [31:0]            s_axi_rdata,    // Read data
  output logic [1:0]             s_axi_rresp,    // Read response
  output logic                   s_axi_rvalid,   // Read data valid
  input  wire logic              s_axi_rready,   // Read data ready
  output logic [PINS0-1:0]       pwm0_pin,       // Channel 0 pins
  output logic [PINS1-1:0]       pwm1_pin,       // Channel 1 pins
  output logic                   irq             // Interrupt request
);

  dpwm_pkg::dpwm_top_st_t st_r;
  dpwm_pkg::dpwm_top_st_t st_nxt;
  logic [1:0]  lvl;
  logic [1:0]  cend;
  logic        awhs;
  logic        whs;
  logic        arhs;
  logic        have_aw;
  logic        have_w;
  logic        wr_do;
  logic [15:0] aw_idx;
  logic [15:0] ar_idx;
  logic [7:0]  wd;
  logic        ws;

  // ****************************************************************
  // Channels
  // ****************************************************************
  dpwm_chan_if cif [2] ();

  for (genvar g = 0; g < 2; g++) begin : g_chan
    assign cif[g].scale = st_r.scale[g];
    assign cif[g].duty = st_r.duty[g];
    assign lvl[g] = cif[g].level;
    assign cend[g] = cif[g].cycle_end;

    dpwm_chan u_chan (
      .aclk    (aclk),
      .aresetn (aresetn),
      .bus     (cif[g].chan)
    );
  end

  // ****************************************************************
  // Bus handshakes
  // ****************************************************************
  assign awhs = s_axi_awvalid && st_r.awready;
  assign whs = s_axi_wvalid && st_r.wready;
  assign arhs = s_axi_arvalid && st_r.arready;
  assign have_aw = st_r.aw_held || awhs;
  assign have_w = st_r.w_held || whs;
  assign wr_do = have_aw && have_w && !st_r.bvalid;
  assign aw_idx = awhs ? s_axi_awaddr[17:2] : st_r.aw_idx;
  assign ar_idx = s_axi_araddr[17:2];
  assign wd = whs ? s_axi_wdata[7:0] : st_r.wdata;
  assign ws = whs ? s_axi_wstrb[0] : st_r.wstrb0;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic clr;
    logic setf;
    logic fbit;
    clr = 1'b0;
    setf = 1'b0;
    fbit = 1'b0;
    st_nxt = st_r;

    // Write channel
    st_nxt.aw_idx = aw_idx;
    st_nxt.wdata = wd;
    st_nxt.wstrb0 = ws;
    st_nxt.aw_held = have_aw && !wr_do;
    st_nxt.w_held = have_w && !wr_do;
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (wr_do) begin
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = `DPWM_RESP_OKAY;
      unique case (aw_idx)
        `DPWM_IDX_C0_SCALE: if (ws) st_nxt.scale[0] = wd;
        `DPWM_IDX_C0_DUTY:  if (ws) st_nxt.duty[0] = wd;
        `DPWM_IDX_C1_SCALE: if (ws) st_nxt.scale[1] = wd;
        `DPWM_IDX_C1_DUTY:  if (ws) st_nxt.duty[1] = wd;
        `DPWM_IDX_FLAG_EN: begin
          if (ws) begin
            st_nxt.en[0] = wd[`DPWM_EN_C0_BIT];
            st_nxt.en[1] = wd[`DPWM_EN_C1_BIT];
          end
        end
        `DPWM_IDX_PIN_SEL: begin
          if (ws) begin
            st_nxt.sel0 = wd[`DPWM_SEL_C0_LSB +: 2];
            st_nxt.sel1 = wd[`DPWM_SEL_C1_LSB +: 2];
          end
        end
        default: st_nxt.bresp = `DPWM_RESP_SLVERR;
      endcase
    end
    st_nxt.awready = !st_nxt.aw_held && !st_nxt.bvalid;
    st_nxt.wready = !st_nxt.w_held && !st_nxt.bvalid;

    // Flags: hardware set wins over a clearing write
    for (int i = 0; i < 2; i++) begin
      fbit = (i == 0) ? wd[`DPWM_FLAG_C0_BIT] : wd[`DPWM_FLAG_C1_BIT];
      clr = wr_do && ws && aw_idx == `DPWM_IDX_FLAG_EN && !fbit;
      setf = cend[i] && st_r.en[i];
      st_nxt.flag[i] = setf || (st_r.flag[i] && !clr);
    end
    st_nxt.irq = |st_nxt.flag;

    // Read channel
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (arhs) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = `DPWM_RESP_OKAY;
      st_nxt.rdata = `DPWM_REG_RST;
      unique case (ar_idx)
        `DPWM_IDX_C0_SCALE: st_nxt.rdata = st_r.scale[0];
        `DPWM_IDX_C0_DUTY:  st_nxt.rdata = st_r.duty[0];
        `DPWM_IDX_C1_SCALE: st_nxt.rdata = st_r.scale[1];
        `DPWM_IDX_C1_DUTY:  st_nxt.rdata = st_r.duty[1];
        `DPWM_IDX_FLAG_EN: begin
          st_nxt.rdata[`DPWM_FLAG_C0_BIT] = st_r.flag[0];
          st_nxt.rdata[`DPWM_FLAG_C1_BIT] = st_r.flag[1];
          st_nxt.rdata[`DPWM_EN_C0_BIT] = st_r.en[0];
          st_nxt.rdata[`DPWM_EN_C1_BIT] = st_r.en[1];
        end
        `DPWM_IDX_PIN_SEL: begin
          st_nxt.rdata[`DPWM_SEL_C0_LSB +: 2] = st_r.sel0;
          st_nxt.rdata[`DPWM_SEL_C1_LSB +: 2] = st_r.sel1;
        end
        default: st_nxt.rresp = `DPWM_RESP_SLVERR;
      endcase
    end
    st_nxt.arready = !st_nxt.rvalid;

    // Pin routing, unselected pins low
    for (int p = 0; p < PINS0; p++) begin
      st_nxt.pin0[p] = lvl[0] && (int'(st_r.sel0) == p);
    end
    for (int p = 0; p < PINS1; p++) begin
      st_nxt.pin1[p] = lvl[1] && (int'(st_r.sel1) == p);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign s_axi_awready = st_r.awready;
  assign s_axi_wready = st_r.wready;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = st_r.arready;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rresp = st_r.rresp;
  assign s_axi_rdata = {24'h000000, st_r.rdata};
  assign pwm0_pin = st_r.pin0[PINS0-1:0];
  assign pwm1_pin = st_r.pin1[PINS1-1:0];
  assign irq = st_r.irq;

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_flag_set;
    @(posedge aclk) disable iff (!aresetn)
    cend[0] && st_r.en[0] |=> st_r.flag[0] ##1 irq;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("Channel 0 flag not set at cycle end");

  property p_flag_cause;
    @(posedge aclk) disable iff (!aresetn)
    $rose(st_r.flag[1]) |-> $past(cend[1]) && $past(st_r.en[1]);
  endproperty
  a_flag_cause: assert property (p_flag_cause)
    else $error("Channel 1 flag set without enabled cycle end");

  property p_flag_clear;
    @(posedge aclk) disable iff (!aresetn)
    wr_do && ws && aw_idx == `DPWM_IDX_FLAG_EN
      && !wd[`DPWM_FLAG_C0_BIT] && !cend[0] |=> !st_r.flag[0];
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("Writing 0 did not clear flag");

  property p_flag_read;
    @(posedge aclk) disable iff (!aresetn)
    arhs && ar_idx == `DPWM_IDX_FLAG_EN |=>
      s_axi_rdata[`DPWM_FLAG_C0_BIT] == $past(st_r.flag[0])
      && s_axi_rdata[`DPWM_EN_C1_BIT] == $past(st_r.en[1]);
  endproperty
  a_flag_read: assert property (p_flag_read)
    else $error("Flag register layout wrong");

  property p_route;
    @(posedge aclk) disable iff (!aresetn)
    st_r.sel1 == 2'h3 |=> pwm1_pin[3] == $past(lvl[1])
      && pwm1_pin[2:0] == 3'h0;
  endproperty
  a_route: assert property (p_route)
    else $error("Channel 1 pin routing wrong");

  property p_indep;
    @(posedge aclk) disable iff (!aresetn)
    wr_do && ws && aw_idx == `DPWM_IDX_C1_SCALE |=> $stable(st_r.scale[0])
      && st_r.scale[1] == $past(wd);
  endproperty
  a_indep: assert property (p_indep)
    else $error("Channel scale registers not independent");

  property p_bresp;
    @(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bresp: assert property (p_bresp)
    else $error("Write response dropped before ready");

  c_flag: cover property (@(posedge aclk) disable iff (!aresetn)
    $rose(irq));
  c_write: cover property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && s_axi_bready);
  c_read: cover property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && s_axi_rready);

endmodule

// ==== tb/dpwm_load.sv ====
/*
  Load model on one PWM output: measures pulse width and period.
  Assumes the pin level is sampled on the system clock.
*/
`timescale 1ns/100ps

module dpwm_load (
  input  wire logic aclk,      // System clock
  input  wire logic aresetn,   // Synchronous reset, low
  input  wire logic pin,       // Level seen on the pin
  output int        high_len,  // Clocks high, last full pulse
  output int        per_len,   // Clocks between last two rises
  output int        rises      // Rising edges seen
);
  // ****************************************************************
  // Edge timing
  // ****************************************************************
  int   hi_r;
  int   per_r;
  logic last_r;

  always @(posedge aclk) begin
    if (!aresetn) begin
      hi_r     <= 0;
      per_r    <= 0;
      last_r   <= 1'b0;
      high_len <= 0;
      per_len  <= 0;
      rises    <= 0;
    end else begin
      last_r <= pin;
      per_r  <= (pin && !last_r) ? 1 : per_r + 1;
      hi_r   <= pin ? (last_r ? hi_r + 1 : 1) : hi_r;
      if (pin && !last_r) begin
        per_len <= per_r;
        rises   <= rises + 1;
      end
      if (!pin && last_r) begin
        high_len <= hi_r;
      end
    end
  end
endmodule

// ==== tb/testbench.sv ====
/*
  Self-checking bench of the dual PWM: AXI4-Lite tasks and pin loads.
  Assumes the register map header and one 125 MHz clock.
*/
`timescale 1ns/100ps
`include "dpwm_map.svh"

module testbench;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [17:0] awaddr = 18'h0, araddr = 18'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [2:0]  pwm0_pin, mask0 = 3'h0;
  logic [3:0]  pwm1_pin, mask1 = 4'h0;
  int          failures = 0, checked = 0, seed = 9;
  int          hl [2], pl [2], rs [2];
  int          d0, d1, t1;
  logic [7:0]  sc;
  wire logic [1:0] pin_any = {|pwm1_pin, |pwm0_pin};

  always #4 aclk = ~aclk;

  dpwm_top dpwm_top_inst (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pwm0_pin(pwm0_pin), .pwm1_pin(pwm1_pin), .irq(irq));

  for (genvar i = 0; i < 2; i++) begin : g_load
    dpwm_load dpwm_load_inst (.aclk(aclk), .aresetn(aresetn),
      .pin(pin_any[i]), .high_len(hl[i]), .per_len(pl[i]), .rises(rs[i]));
  end

  // ****************************************************************
  // Checking and closing
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      failures++;
    end
  endtask

  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic hang(input string nm);
    $display("[FAIL] %s expected done seen timeout", nm);
    failures++;
    end_sim();
  endtask

  function automatic int tk(input logic [7:0] s);
    return (2 << s[7:5]) * (int'(s[4:0]) + 1);
  endfunction

  // ****************************************************************
  // Bus cycles
  // ****************************************************************
  task automatic wr(input logic [15:0] a, input logic [7:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    int n;
    @(posedge aclk);
    awaddr <= {a, 2'b00};
    awvalid <= 1'b1;
    wdata <= {24'h0, d};
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && n < 100);
    if (!bvalid) hang("bvalid");
    bready <= 1'b0;
    chk("bresp", er, bresp);
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] ed,
                    input logic [1:0] er);
    int n;
    @(posedge aclk);
    araddr <= {a, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid && n < 100);
    if (!rvalid) hang("rvalid");
    rready <= 1'b0;
    chk("rdata", {24'h0, ed}, rdata);
    chk("rresp", er, rresp);
  endtask

  task automatic wk(input logic [15:0] a, input logic [7:0] d);
    wr(a, d, 4'h1, `DPWM_RESP_OKAY);
  endtask

  task automatic rise(input int ch, input int k, input int lim);
    int r0;
    int n;
    r0 = rs[ch];
    n = 0;
    while (rs[ch] < r0 + k && n < lim) begin
      @(posedge aclk);
      n++;
    end
    if (rs[ch] < r0 + k) hang("pin rise");
  endtask

  // Only the selected pin may carry the channel level
  always @(negedge aclk) begin
    if (aresetn && pwm0_pin !== 3'h0 && pwm0_pin !== mask0)
      chk("pwm0_pin", mask0, pwm0_pin);
    if (aresetn && pwm1_pin !== 4'h0 && pwm1_pin !== mask1)
      chk("pwm1_pin", mask1, pwm1_pin);
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 6; i++)
      rd(16'ha088 + 16'(i), 8'h00, `DPWM_RESP_OKAY);
    rd(16'ha08e, 8'h00, `DPWM_RESP_SLVERR);
    wr(16'ha08e, 8'h55, 4'h1, `DPWM_RESP_SLVERR);
    $display("test reset_map done");
    mask0 = 3'h2;
    mask1 = 4'h4;
    wk(`DPWM_IDX_PIN_SEL, 8'h21);
    wk(`DPWM_IDX_C0_DUTY, 8'h80);
    wk(`DPWM_IDX_C0_SCALE, 8'h20);
    rise(0, 3, 5000);
    chk("period0", 1024, pl[0]);
    chk("high0", 512, hl[0]);
    rise(0, 1, 2000);
    repeat (20) @(posedge aclk);
    wk(`DPWM_IDX_C0_DUTY, 8'h40);
    rise(0, 1, 2000);
    chk("high0 held", 512, hl[0]);
    rise(0, 1, 2000);
    chk("high0 new", 256, hl[0]);
    wr(`DPWM_IDX_C0_DUTY, 8'h10, 4'he, `DPWM_RESP_OKAY);
    rd(`DPWM_IDX_C0_DUTY, 8'h40, `DPWM_RESP_OKAY);
    wk(`DPWM_IDX_C0_DUTY, 8'hff);
    rise(0, 3, 5000);
    chk("high0 max", 1020, hl[0]);
    wk(`DPWM_IDX_C0_DUTY, 8'h00);
    repeat (1100) @(posedge aclk);
    d0 = rs[0];
    repeat (2100) @(posedge aclk);
    chk("rises duty0", d0, rs[0]);
    $display("test chan0_basic done");
    for (int it = 0; it < 2; it++) begin
      wk(`DPWM_IDX_C1_SCALE, 8'he0);
      repeat (4) @(posedge aclk);
      chk("hold high", mask1, pwm1_pin);
      wk(`DPWM_IDX_C1_SCALE, 8'h00);
      repeat (4) @(posedge aclk);
      chk("hold low", 4'h0, pwm1_pin);
      d0 = 1 + $unsigned($random(seed)) % 254;
      d1 = 1 + $unsigned($random(seed)) % 254;
      sc = 8'(((1 + $unsigned($random(seed)) % 2) << 5)
              | (1 + $unsigned($random(seed)) % 2));
      t1 = tk(sc);
      wk(`DPWM_IDX_C0_DUTY, 8'(d0));
      wk(`DPWM_IDX_C1_DUTY, 8'(d1));
      wk(`DPWM_IDX_C1_SCALE, sc);
      rise(1, 3, 20000);
      chk("period1", 256 * t1, pl[1]);
      chk("high1", d1 * t1, hl[1]);
      chk("high0 indep", d0 * 4, hl[0]);
    end
    $display("test random_scale done");
    wk(`DPWM_IDX_C0_SCALE, 8'h00);
    wk(`DPWM_IDX_C1_SCALE, 8'h00);
    wk(`DPWM_IDX_C0_DUTY, 8'h01);
    wk(`DPWM_IDX_C1_DUTY, 8'h01);
    wk(`DPWM_IDX_C0_SCALE, 8'hc0);
    wk(`DPWM_IDX_C1_SCALE, 8'h3f);
    repeat (8) @(posedge aclk);
    rise(0, 1, 34000);
    rise(1, 1, 2000);
    repeat (300) @(posedge aclk);
    chk("tick presc128", 128, hl[0]);
    chk("tick div32", 128, hl[1]);
    $display("test scale_limits done");
    wk(`DPWM_IDX_C0_SCALE, 8'h20);
    wk(`DPWM_IDX_C1_SCALE, 8'h20);
    wk(`DPWM_IDX_FLAG_EN, 8'h04);
    rise(1, 2, 3000);
    repeat (4) @(posedge aclk);
    rd(`DPWM_IDX_FLAG_EN, 8'h44, `DPWM_RESP_OKAY);
    chk("irq set", 1'b1, irq);
    wk(`DPWM_IDX_FLAG_EN, 8'h04);
    rd(`DPWM_IDX_FLAG_EN, 8'h04, `DPWM_RESP_OKAY);
    chk("irq clear", 1'b0, irq);
    wk(`DPWM_IDX_FLAG_EN, 8'hc8);
    rd(`DPWM_IDX_FLAG_EN, 8'h08, `DPWM_RESP_OKAY);
    rise(0, 1, 3000);
    rise(1, 1, 3000);
    repeat (4) @(posedge aclk);
    rd(`DPWM_IDX_FLAG_EN, 8'h88, `DPWM_RESP_OKAY);
    chk("irq ch0", 1'b1, irq);
    wk(`DPWM_IDX_FLAG_EN, 8'h00);
    $display("test flags done");
    wk(`DPWM_IDX_C0_SCALE, 8'h00);
    wk(`DPWM_IDX_C1_SCALE, 8'h00);
    repeat (4) @(posedge aclk);
    mask0 = 3'h0;
    mask1 = 4'h8;
    wk(`DPWM_IDX_PIN_SEL, 8'h33);
    wk(`DPWM_IDX_C0_SCALE, 8'he0);
    wk(`DPWM_IDX_C1_SCALE, 8'he0);
    repeat (4) @(posedge aclk);
    chk("pin none", 3'h0, pwm0_pin);
    chk("pin last", 4'h8, pwm1_pin);
    wk(`DPWM_IDX_C0_SCALE, 8'h00);
    wk(`DPWM_IDX_C1_SCALE, 8'h00);
    repeat (4) @(posedge aclk);
    mask0 = 3'h4;
    mask1 = 4'h1;
    wk(`DPWM_IDX_PIN_SEL, 8'h02);
    wk(`DPWM_IDX_C0_SCALE, 8'he0);
    wk(`DPWM_IDX_C1_SCALE, 8'he0);
    repeat (4) @(posedge aclk);
    chk("pin0 third", 3'h4, pwm0_pin);
    chk("pin1 first", 4'h1, pwm1_pin);
    $display("test pin_route done");
    end_sim();
  end
endmodule
